// ===== src/gpio_config_monitor_pkg.sv
// constants for the pin function, output value, monitor and interrupt configuration block
// assumes a classic wishbone slave with 32-bit data, registers in the low byte of each word
package gpio_config_monitor_pkg;
	// register indices; byte address is four times the index
	localparam logic [7:0] IDX_INPUT_PIN2_FUNCTION = 8'h25;
	localparam logic [7:0] IDX_PIN_OUTPUT_VALUES = 8'h26;
	localparam logic [7:0] IDX_PIN_INPUT_MONITOR = 8'h27;
	localparam logic [7:0] IDX_INTERRUPT_CONFIGURATION = 8'h28;
	localparam logic [7:0] IDX_PIN_MODE = 8'h30;
	localparam logic [7:0] IDX_EVENT_LATCH = 8'h31;
	localparam int ADR_LSB = 2;
	localparam int ADR_MSB = 9;

	// reset values
	localparam logic [7:0] RST_INPUT_PIN2_FUNCTION = 8'h00;
	localparam logic [7:0] RST_PIN_OUTPUT_VALUES = 8'h00;
	localparam logic [7:0] RST_PIN_INPUT_MONITOR = 8'h00;
	localparam logic [7:0] RST_INTERRUPT_CONFIGURATION = 8'h00;
	localparam logic [7:0] RST_PIN_MODE = 8'h00;

	// input pin 2 function select field
	localparam int SEL_MSB = 7;
	localparam int SEL_LSB = 4;
	localparam logic [3:0] FN_DISABLED = 4'h0;
	localparam logic [3:0] FN_POWERDOWN = 4'h7;
	localparam logic [3:0] FN_BIAS_CONTROL = 4'h8;
	localparam logic [3:0] FN_GENERAL_INPUT = 4'h9;
	localparam logic [3:0] FN_MASTER_CLOCK = 4'ha;
	localparam logic [3:0] FN_DAISY_CHAIN = 4'hb;

	// output value and monitor bit positions
	localparam int BIT_BIDIR1 = 7;
	localparam int BIT_BIDIR2 = 6;
	localparam int BIT_BIDIR3 = 5;
	localparam int BIT_INPUT1 = 4;
	localparam int BIT_INPUT2 = 3;
	localparam logic [7:0] MASK_OUTPUT_VALUES = 8'he0;
	localparam logic [7:0] MASK_MONITOR = 8'hf8;

	// interrupt configuration fields
	localparam int BIT_INT_POLARITY = 7;
	localparam int EVENT_STYLE_MSB = 6;
	localparam int EVENT_STYLE_LSB = 5;
	localparam int FAULT_PD_MSB = 4;
	localparam int FAULT_PD_LSB = 3;
	localparam int BIT_LATCH_READBACK = 2;
	localparam int BIT_FAULT_RECOVERY = 1;
	localparam int BIT_CLEAR_ON_READ = 0;

	// pin mode register: bits 7..5 output enable, 4..2 input enable, 1 input pin 1 enable
	localparam int MODE_GPO1 = 7;
	localparam int MODE_GPO2 = 6;
	localparam int MODE_GPO3 = 5;
	localparam int MODE_GPI1 = 4;
	localparam int MODE_GPI2 = 3;
	localparam int MODE_GPI3 = 2;
	localparam int MODE_IN1 = 1;
	localparam logic [7:0] MASK_PIN_MODE = 8'hfe;

	// event latch register
	localparam int BIT_LATCH = 0;
	localparam int BIT_LIVE = 1;
endpackage

// ===== src/gpio_config_monitor.sv
// pin function select, output values, pin monitor and interrupt configuration registers
// assumes one 250 MHz clock, synchronous active-low reset, classic wishbone master,
// pins asynchronous to clk_i, event status input from logic on clk_i
//
// Local design decision: the Wishbone interface to the registers.
`timescale 1ns/100ps

// Function
// RQ1: four-bit select in bits 7..4 picks input pin 2 function; zero disables it.
// RQ2: software must not program reserved codes 1 to 6, 12 or 13.
// RQ3: code seven makes input pin 2 power down all converter channels.
// RQ4: code eight makes input pin 2 switch the microphone bias supply.
// RQ5: code nine makes input pin 2 a general input readable by software.
// RQ6: code ten takes the master clock from input pin 2.
// RQ7: code eleven feeds daisy-chain serial data from input pin 2 to serial port.
// RQ8: bidir pin 1 as output drives output value bit 7.
// RQ9: bidir pin 2 as output drives output value bit 6.
// RQ10: bidir pin 3 as output drives output value bit 5.
// RQ11: bidir pin 1 as input shows its level in monitor bit 7.
// RQ12: bidir pin 2 as input shows its level in monitor bit 6.
// RQ13: bidir pin 3 as input shows its level in monitor bit 5.
// RQ14: input pin 1 as general input shows its level in monitor bit 4.
// RQ15: input pin 2 as general input shows its level in monitor bit 3.
// RQ16: monitor register is read-only, zero after reset, bits 2..0 zero.
// RQ17: interrupt configuration register resets to zero with documented field layout.
// RQ18: interrupt output active low at polarity zero, active high at one.
// RQ19: clear-on-read zero clears latched bit on read only when live status zero.
// RQ20: reserved bits read zero and ignore writes.
module gpio_config_monitor (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [9:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic [2:0] bidir_pin_i,
	output logic [2:0] bidir_pin_o,
	output logic [2:0] bidir_pin_oe_o,
	input wire logic input_pin1_i,
	input wire logic input_pin2_i,
	input wire logic event_live_i,
	output logic adc_powerdown_o,
	output logic microphone_bias_supply_o,
	output logic master_clock_select_o,
	output logic master_clock_o,
	output logic daisy_chain_select_o,
	output logic daisy_chain_serial_input_o,
	output logic fault_recovery_manual_o,
	output logic [1:0] fault_powerdown_select_o,
	output logic latch_readback_select_o,
	output logic [1:0] event_style_o,
	output logic interrupt_o
);

	typedef struct packed {
		logic [7:0] fn_sel;
		logic [7:0] out_val;
		logic [7:0] monitor;
		logic [7:0] int_cfg;
		logic [7:0] pin_mode;
		logic [4:0] sync1;
		logic [4:0] sync2;
		logic latch;
		logic live_d;
		logic ack;
		logic [31:0] rdata;
		logic pd;
		logic bias;
		logic mclk_sel;
		logic chain_sel;
		logic [2:0] pin_out;
		logic [2:0] pin_oe;
		logic irq;
	} state_s;

	state_s st_r;
	state_s st_nxt;

	// index decode, used for both write and read paths
	function automatic logic hit(input logic [9:0] adr, input logic [7:0] idx);
		hit = (adr[gpio_config_monitor_pkg::ADR_MSB:gpio_config_monitor_pkg::ADR_LSB] == idx);
	endfunction

	logic req;
	logic wr;
	logic rd;
	logic lane0;
	logic [7:0] wbyte;
	logic [4:0] lvl;
	logic [3:0] code;
	logic latch_clear;
	logic latch_set;

	// request qualifiers; ack drops the cycle after it is given
	assign req = wb_cyc_i & wb_stb_i & ~st_r.ack;
	assign wr = req & wb_we_i;
	assign rd = req & ~wb_we_i;
	assign lane0 = wb_sel_i[0];
	assign wbyte = wb_dat_i[7:0];
	assign lvl = st_r.sync2;
	assign code = st_r.fn_sel[gpio_config_monitor_pkg::SEL_MSB:gpio_config_monitor_pkg::SEL_LSB];

	// latch handling: clear on a read of the latch register
	always_comb begin
		latch_set = 1'b0;
		latch_clear = 1'b0;
		if (st_r.int_cfg[gpio_config_monitor_pkg::BIT_CLEAR_ON_READ]) begin
			latch_set = event_live_i & ~st_r.live_d; // only a fresh rising edge re-arms [RQ19]
		end else begin
			latch_set = event_live_i;
		end
		if (rd && hit(wb_adr_i, gpio_config_monitor_pkg::IDX_EVENT_LATCH)) begin
			if (st_r.int_cfg[gpio_config_monitor_pkg::BIT_CLEAR_ON_READ]) begin
				latch_clear = 1'b1;
			end else begin
				latch_clear = ~event_live_i; // a live event keeps its latch [RQ19]
			end
		end
	end

	// next-state logic for all registers
	always_comb begin
		st_nxt = st_r;
		st_nxt.ack = req;
		// pin synchronisers: first stage feeds only the second
		st_nxt.sync1 = {bidir_pin_i, input_pin1_i, input_pin2_i};
		st_nxt.sync2 = st_r.sync1;
		st_nxt.live_d = event_live_i;

		// register writes on the low byte lane; reserved bits masked off [RQ20]
		if (wr && lane0) begin
			if (hit(wb_adr_i, gpio_config_monitor_pkg::IDX_INPUT_PIN2_FUNCTION)) begin
				st_nxt.fn_sel = {wbyte[gpio_config_monitor_pkg::SEL_MSB:gpio_config_monitor_pkg::SEL_LSB],
					4'h0}; // [RQ1] [RQ20]
			end else if (hit(wb_adr_i, gpio_config_monitor_pkg::IDX_PIN_OUTPUT_VALUES)) begin
				st_nxt.out_val = wbyte & gpio_config_monitor_pkg::MASK_OUTPUT_VALUES; // [RQ20]
			end else if (hit(wb_adr_i, gpio_config_monitor_pkg::IDX_INTERRUPT_CONFIGURATION)) begin
				st_nxt.int_cfg = wbyte; // [RQ17]
			end else if (hit(wb_adr_i, gpio_config_monitor_pkg::IDX_PIN_MODE)) begin
				st_nxt.pin_mode = wbyte & gpio_config_monitor_pkg::MASK_PIN_MODE;
			end
		end

		// monitor bits follow the pin only in input mode, otherwise zero [RQ16]
		st_nxt.monitor = 8'h00;
		st_nxt.monitor[gpio_config_monitor_pkg::BIT_BIDIR1] =
			st_r.pin_mode[gpio_config_monitor_pkg::MODE_GPI1] & lvl[4]; // [RQ11]
		st_nxt.monitor[gpio_config_monitor_pkg::BIT_BIDIR2] =
			st_r.pin_mode[gpio_config_monitor_pkg::MODE_GPI2] & lvl[3]; // [RQ12]
		st_nxt.monitor[gpio_config_monitor_pkg::BIT_BIDIR3] =
			st_r.pin_mode[gpio_config_monitor_pkg::MODE_GPI3] & lvl[2]; // [RQ13]
		st_nxt.monitor[gpio_config_monitor_pkg::BIT_INPUT1] =
			st_r.pin_mode[gpio_config_monitor_pkg::MODE_IN1] & lvl[1]; // [RQ14]
		st_nxt.monitor[gpio_config_monitor_pkg::BIT_INPUT2] =
			(code == gpio_config_monitor_pkg::FN_GENERAL_INPUT) & lvl[0]; // [RQ5] [RQ15]

		// input pin 2 functions; reserved and disabled codes leave every path idle
		st_nxt.pd = (code == gpio_config_monitor_pkg::FN_POWERDOWN) & lvl[0]; // [RQ3]
		st_nxt.bias = (code == gpio_config_monitor_pkg::FN_BIAS_CONTROL) & lvl[0]; // [RQ4]
		st_nxt.mclk_sel = (code == gpio_config_monitor_pkg::FN_MASTER_CLOCK); // [RQ6]
		st_nxt.chain_sel = (code == gpio_config_monitor_pkg::FN_DAISY_CHAIN); // [RQ7]
		if (code == gpio_config_monitor_pkg::FN_DISABLED) begin
			st_nxt.pd = 1'b0; // [RQ1]
		end

		// bidir output drivers
		st_nxt.pin_out = {st_r.out_val[gpio_config_monitor_pkg::BIT_BIDIR1], // [RQ8]
			st_r.out_val[gpio_config_monitor_pkg::BIT_BIDIR2], // [RQ9]
			st_r.out_val[gpio_config_monitor_pkg::BIT_BIDIR3]}; // [RQ10]
		st_nxt.pin_oe = {st_r.pin_mode[gpio_config_monitor_pkg::MODE_GPO1],
			st_r.pin_mode[gpio_config_monitor_pkg::MODE_GPO2],
			st_r.pin_mode[gpio_config_monitor_pkg::MODE_GPO3]};

		// latched event: set wins over the read clear
		if (latch_set) begin
			st_nxt.latch = 1'b1;
		end else if (latch_clear) begin
			st_nxt.latch = 1'b0; // [RQ19]
		end
		// polarity applied on the registered latch bit [RQ18]
		st_nxt.irq = st_r.int_cfg[gpio_config_monitor_pkg::BIT_INT_POLARITY] ? st_r.latch : ~st_r.latch;

		// read data, unmapped indices read zero
		st_nxt.rdata = 32'h0000_0000;
		if (rd) begin
			if (hit(wb_adr_i, gpio_config_monitor_pkg::IDX_INPUT_PIN2_FUNCTION)) begin
				st_nxt.rdata[7:0] = st_r.fn_sel;
			end else if (hit(wb_adr_i, gpio_config_monitor_pkg::IDX_PIN_OUTPUT_VALUES)) begin
				st_nxt.rdata[7:0] = st_r.out_val;
			end else if (hit(wb_adr_i, gpio_config_monitor_pkg::IDX_PIN_INPUT_MONITOR)) begin
				st_nxt.rdata[7:0] = st_r.monitor & gpio_config_monitor_pkg::MASK_MONITOR; // [RQ16]
			end else if (hit(wb_adr_i, gpio_config_monitor_pkg::IDX_INTERRUPT_CONFIGURATION)) begin
				st_nxt.rdata[7:0] = st_r.int_cfg; // [RQ17]
			end else if (hit(wb_adr_i, gpio_config_monitor_pkg::IDX_PIN_MODE)) begin
				st_nxt.rdata[7:0] = st_r.pin_mode;
			end else if (hit(wb_adr_i, gpio_config_monitor_pkg::IDX_EVENT_LATCH)) begin
				st_nxt.rdata[gpio_config_monitor_pkg::BIT_LATCH] = st_r.latch;
				st_nxt.rdata[gpio_config_monitor_pkg::BIT_LIVE] = event_live_i;
			end
		end
	end

	// single state register; irq resets to the inactive low-active level
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			st_r <= '0;
			st_r.fn_sel <= gpio_config_monitor_pkg::RST_INPUT_PIN2_FUNCTION;
			st_r.out_val <= gpio_config_monitor_pkg::RST_PIN_OUTPUT_VALUES;
			st_r.monitor <= gpio_config_monitor_pkg::RST_PIN_INPUT_MONITOR;
			st_r.int_cfg <= gpio_config_monitor_pkg::RST_INTERRUPT_CONFIGURATION;
			st_r.pin_mode <= gpio_config_monitor_pkg::RST_PIN_MODE;
			st_r.irq <= 1'b1;
		end else begin
			st_r <= st_nxt;
		end
	end

	// outputs; clock and serial data are gated, not resampled, to keep their edges
	assign wb_ack_o = st_r.ack;
	assign wb_dat_o = st_r.rdata;
	assign bidir_pin_o = st_r.pin_out;
	assign bidir_pin_oe_o = st_r.pin_oe;
	assign adc_powerdown_o = st_r.pd;
	assign microphone_bias_supply_o = st_r.bias;
	assign master_clock_select_o = st_r.mclk_sel;
	assign master_clock_o = st_r.mclk_sel & input_pin2_i; // [RQ6]
	assign daisy_chain_select_o = st_r.chain_sel;
	assign daisy_chain_serial_input_o = st_r.chain_sel & input_pin2_i; // [RQ7]
	assign fault_recovery_manual_o = st_r.int_cfg[gpio_config_monitor_pkg::BIT_FAULT_RECOVERY];
	assign fault_powerdown_select_o =
		st_r.int_cfg[gpio_config_monitor_pkg::FAULT_PD_MSB:gpio_config_monitor_pkg::FAULT_PD_LSB];
	assign latch_readback_select_o = st_r.int_cfg[gpio_config_monitor_pkg::BIT_LATCH_READBACK];
	assign event_style_o =
		st_r.int_cfg[gpio_config_monitor_pkg::EVENT_STYLE_MSB:gpio_config_monitor_pkg::EVENT_STYLE_LSB];
	assign interrupt_o = st_r.irq;

endmodule // gpio_config_monitor

// ===== test/gpio_config_monitor_asserts.sv
// port-level checker for the pin function and configuration block
// assumes it is bound onto every instance, one clock domain
`timescale 1ns/100ps
module gpio_config_monitor_asserts (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [9:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic [2:0] bidir_pin_o,
	input wire logic [2:0] bidir_pin_oe_o,
	input wire logic input_pin2_i,
	input wire logic event_live_i,
	input wire logic adc_powerdown_o,
	input wire logic microphone_bias_supply_o,
	input wire logic master_clock_select_o,
	input wire logic master_clock_o,
	input wire logic daisy_chain_select_o,
	input wire logic daisy_chain_serial_input_o,
	input wire logic fault_recovery_manual_o,
	input wire logic [1:0] fault_powerdown_select_o,
	input wire logic latch_readback_select_o,
	input wire logic [1:0] event_style_o,
	input wire logic interrupt_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	logic pol_r;
	logic cor_r;
	logic [2:0] vals_r;
	logic wr_cfg;
	// own copy of the polarity bit, so a design ignoring it disagrees here
	assign wr_cfg = wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i[9:2] == 8'h28;
	always_ff @(posedge clk_i) begin
		pol_r <= !rst_n_i ? 1'b0 : wr_cfg ? wb_dat_i[7] : pol_r;
		cor_r <= !rst_n_i ? 1'b0 : wr_cfg ? wb_dat_i[0] : cor_r;
		vals_r <= wb_dat_i[7:5];
	end
	sequence req_s; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
	sequence val_wr_s; wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i[9:2] == 8'h26; endsequence
	sequence live_s; event_live_i [*2]; endsequence
	ack_pulse_a: assert property (req_s |=> wb_ack_o ##1 !wb_ack_o) else $error("ack is not a one-cycle answer");
	drive_vals_a: assert property (val_wr_s |=> (bidir_pin_o & bidir_pin_oe_o) == (vals_r & bidir_pin_oe_o))
		else $error("driven pin differs from value written");
	cfg_fields_a: assert property (wr_cfg |-> {event_style_o, fault_powerdown_select_o, latch_readback_select_o,
		fault_recovery_manual_o} == wb_dat_i[6:1]) else $error("config field outputs wrong");
	// with clear-on-read set a read may drop the latch under a live event, so only level mode is held here
	irq_level_a: assert property (live_s |=> cor_r || interrupt_o == pol_r) else $error("interrupt level wrong");
	mclk_gate_a: assert property (master_clock_o == (master_clock_select_o && input_pin2_i))
		else $error("clock path not gated by select");
	daisy_gate_a: assert property (daisy_chain_serial_input_o == (daisy_chain_select_o && input_pin2_i))
		else $error("serial path not gated by select");
	one_func_a: assert property ($onehot0({adc_powerdown_o, microphone_bias_supply_o, master_clock_select_o,
		daisy_chain_select_o})) else $error("two pin functions at once");
	rsv_zero_a: assert property (wb_ack_o && !wb_we_i |-> wb_dat_o[31:8] == 24'h0 && (wb_adr_i[9:2] != 8'h27 ||
		wb_dat_o[2:0] == 3'h0)) else $error("reserved bits read nonzero");
endmodule // gpio_config_monitor_asserts
bind gpio_config_monitor gpio_config_monitor_asserts i_gpio_config_monitor_asserts (.*);

// ===== test/board_pins.sv
// board side of the three two-way pins: external drivers and wire level
// assumes the bench sets what the board drives when the block is not driving
`timescale 1ns/100ps
module board_pins (
	input wire logic [2:0] pin_o,
	input wire logic [2:0] pin_oe,
	input wire logic [2:0] board_i,
	output logic [2:0] level_o
);
	// board drivers are weak, the enabled block driver always wins
	always_comb level_o = (pin_oe & pin_o) | (~pin_oe & board_i);
endmodule // board_pins

// ===== test/gpio_config_monitor_tb.sv
// self-checking bench: wishbone register accesses, board pins modelled
// assumes the checker is bound onto the block
`timescale 1ns/100ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin error_cnt++; $display("Error t=%0t got %h exp %h", $time, a, b); end end
module gpio_config_monitor_tb;
	logic clk_i = '0, rst_n_i = '0, wb_cyc_i = '0, wb_stb_i = '0, wb_we_i = '0;
	logic input_pin1_i = '0, input_pin2_i = '0, event_live_i = '0;
	logic [9:0] wb_adr_i = '0;
	logic [3:0] wb_sel_i = '0;
	logic [31:0] wb_dat_i = '0, wb_dat_o, q;
	logic [2:0] bidir_pin_i, bidir_pin_o, bidir_pin_oe_o, board = '0;
	logic wb_ack_o, adc_powerdown_o, microphone_bias_supply_o, master_clock_select_o, master_clock_o;
	logic daisy_chain_select_o, daisy_chain_serial_input_o, fault_recovery_manual_o, latch_readback_select_o, interrupt_o;
	logic [1:0] fault_powerdown_select_o, event_style_o;
	int error_cnt = 0, num_checks = 0;
	logic [3:0] codes [6] = '{4'h0, 4'h7, 4'h8, 4'ha, 4'hb, 4'h9}; // legal codes only
	logic [7:0] vals [2] = '{8'ha0, 8'h5f};
	gpio_config_monitor i_gpio_config_monitor (.*);
	board_pins i_board_pins (.pin_o(bidir_pin_o), .pin_oe(bidir_pin_oe_o), .board_i(board), .level_o(bidir_pin_i));
	initial forever #2 clk_i = ~clk_i;
	// one classic cycle; request held until ack is sampled, then released
	task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_sel_i <= 4'h1;
		wb_adr_i <= {a, 2'b00};
		wb_dat_i <= {24'h0, d};
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 20);
		if (wb_ack_o !== 1'b1) error_cnt++;
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask
	task automatic chk_rd(input logic [7:0] a, input logic [7:0] e);
		bus(1'b0, a, 8'h00);
		`CHK(q, {24'h0, e})
	endtask
	task automatic summarize();
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	// watchdog; the whole run needs well under a thousand cycles
	initial begin
		repeat (4000) @(posedge clk_i);
		error_cnt++;
		summarize();
	end
	initial begin
		repeat (16) @(posedge clk_i);
		rst_n_i <= 1'b1;
		for (int a = 8'h25; a < 8'h29; a++) chk_rd(a[7:0], 8'h00);
		`CHK(interrupt_o, 1'b1)
		// every legal function code, low nibble written with ones
		input_pin2_i <= 1'b1;
		foreach (codes[i]) begin
			bus(1'b1, 8'h25, {codes[i], 4'hf});
			repeat (4) @(posedge clk_i);
			chk_rd(8'h25, {codes[i], 4'h0});
			`CHK({adc_powerdown_o, microphone_bias_supply_o}, {codes[i] == 4'h7, codes[i] == 4'h8})
			`CHK({master_clock_o, daisy_chain_serial_input_o}, {codes[i] == 4'ha, codes[i] == 4'hb})
			`CHK({master_clock_select_o, daisy_chain_select_o}, {codes[i] == 4'ha, codes[i] == 4'hb})
			chk_rd(8'h27, {4'h0, codes[i] == 4'h9, 3'h0});
		end
		// two-way pins as outputs, board pulling against them
		board <= 3'b010;
		bus(1'b1, 8'h30, 8'he0);
		foreach (vals[i]) begin
			bus(1'b1, 8'h26, vals[i]);
			repeat (2) @(posedge clk_i);
			`CHK({bidir_pin_oe_o, bidir_pin_i}, {3'b111, vals[i][7:5]})
			chk_rd(8'h26, vals[i] & 8'he0);
		end
		// all pins sampling; a write to the monitor must not stick
		bus(1'b1, 8'h30, 8'h1e);
		foreach (vals[i]) begin
			board <= vals[i][7:5];
			input_pin1_i <= vals[i][4];
			input_pin2_i <= vals[i][3];
			repeat (5) @(posedge clk_i);
			bus(1'b1, 8'h27, 8'hff);
			chk_rd(8'h27, vals[i] & 8'hf8);
		end
		// active-high interrupt; read clears only once live status drops
		bus(1'b1, 8'h28, 8'h80);
		repeat (2) @(posedge clk_i);
		`CHK(interrupt_o, 1'b0)
		event_live_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		`CHK(interrupt_o, 1'b1)
		chk_rd(8'h31, 8'h03);
		repeat (2) @(posedge clk_i);
		`CHK(interrupt_o, 1'b1)
		event_live_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		chk_rd(8'h31, 8'h01);
		repeat (2) @(posedge clk_i);
		`CHK(interrupt_o, 1'b0)
		bus(1'b1, 8'h28, 8'h7f);
		`CHK({event_style_o, fault_powerdown_select_o, latch_readback_select_o, fault_recovery_manual_o}, 6'h3f)
		chk_rd(8'h28, 8'h7f);
		// clear-on-read mode, active low: a read clears under a live event, no re-arm without a new edge
		event_live_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		`CHK(interrupt_o, 1'b0)
		chk_rd(8'h31, 8'h03);
		chk_rd(8'h31, 8'h02);
		`CHK(interrupt_o, 1'b1)
		event_live_i <= 1'b0;
		chk_rd(8'h3f, 8'h00);
		summarize();
	end
endmodule // gpio_config_monitor_tb
